// file: hw/lnkh_pkg.sv
package lnkh_pkg;
	// ************************************************************
	// register map of the controller's own command port
	// ************************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STN = 8'h08;
	localparam logic [7:0] REG_HEAD = 8'h0C;
	localparam logic [7:0] REG_CNT = 8'h10;
	localparam logic [7:0] REG_STAT = 8'h14;
	localparam logic [7:0] REG_BIDX = 8'h18;
	localparam logic [7:0] REG_DATA = 8'h1C;
	localparam logic [7:0] REG_RXCNT = 8'h20;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_CLEAR_BIT = 1;
	localparam logic [7:0] RST_PLC_NO = 8'hFF;
	// ************************************************************
	// link characters, limits, timing
	// ************************************************************
	localparam logic [7:0] CH_ENQ = 8'h05;
	localparam logic [7:0] CH_STX = 8'h02;
	localparam logic [7:0] CH_ETX = 8'h03;
	localparam logic [7:0] CH_ACK = 8'h06;
	localparam logic [7:0] CH_NAK = 8'h15;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_ONE = 8'h31;
	localparam logic [7:0] ERR_MODE_SAME = 8'h18;
	localparam logic [7:0] LIM_WORD = 8'h40;
	localparam logic [7:0] LIM_BIT_RD = 8'h20;
	localparam logic [7:0] LIM_LONG = 8'h20;
	localparam logic [7:0] LIM_BIT_WR = 8'h0A;
	localparam logic [7:0] LIM_WORD_RED = 8'h0B;
	localparam logic [7:0] LIM_LONG_RED = 8'h05;
	localparam logic [7:0] LIM_BW = 8'hA0;
	localparam logic [7:0] LIM_BW_RED = 8'h2E;
	localparam logic [7:0] LIM_BT = 8'h14;
	localparam logic [7:0] LIM_BT_RED = 8'h0A;
	localparam logic [7:0] LIM_WT = 8'h0A;
	localparam logic [7:0] LIM_WT_RED = 8'h06;
	localparam int BITS_PER_UNIT = 16;
	localparam int WAIT_STEP_MS = 10;
	localparam int CLK_KHZ = 100000;
	localparam int RSP_TIMEOUT_MS = 500;
	localparam int RSP_TIMEOUT_CYCLES = RSP_TIMEOUT_MS * CLK_KHZ;
	localparam int RX_SKIP_CHARS = 4;

	typedef enum logic [3:0] {
		ext_word_read_cmd = 4'h0, bit_block_write_cmd = 4'h1, word_block_write_cmd = 4'h2,
		ext_word_block_write_cmd = 4'h3, bit_test_write_cmd = 4'h4, word_test_write_cmd = 4'h5,
		ext_word_test_write_cmd = 4'h6, remote_run_cmd = 4'h7, remote_stop_cmd = 4'h8
	} lnkh_cmd_t;
	typedef enum logic [1:0] {kind_bit = 2'h0, kind_word = 2'h1, kind_long = 2'h2} lnkh_kind_t;
	typedef struct packed {
		logic ext_ok;
		logic reduced;
		lnkh_kind_t kind;
		lnkh_cmd_t cmd;
	} lnkh_cfg_t;
	typedef struct packed {
		logic forced_run;
		logic mode_same;
		logic timeout;
		logic sum_err;
		logic nak;
		logic lim_err;
		logic done;
		logic busy;
	} lnkh_stat_t;

	function automatic logic [7:0] hex_ch(input logic [3:0] n);
		hex_ch = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction
	function automatic logic [3:0] hex_val(input logic [7:0] c);
		hex_val = (c >= 8'h41) ? 4'(c - 8'h37) : 4'(c - 8'h30);
	endfunction
	function automatic logic [3:0] nib16(input logic [15:0] v, input logic [1:0] k);
		nib16 = 4'(v >> (4'd12 - {k, 2'b00}));
	endfunction
	function automatic logic [7:0] cmd_ch(input lnkh_cmd_t c, input logic second);
		case (c)
			ext_word_read_cmd: cmd_ch = second ? 8'h52 : 8'h51;
			bit_block_write_cmd: cmd_ch = second ? 8'h57 : 8'h42;
			word_block_write_cmd: cmd_ch = second ? 8'h57 : 8'h57;
			ext_word_block_write_cmd: cmd_ch = second ? 8'h57 : 8'h51;
			bit_test_write_cmd: cmd_ch = second ? 8'h54 : 8'h42;
			word_test_write_cmd: cmd_ch = second ? 8'h54 : 8'h57;
			ext_word_test_write_cmd: cmd_ch = second ? 8'h54 : 8'h51;
			remote_run_cmd: cmd_ch = second ? 8'h52 : 8'h52;
			default: cmd_ch = second ? 8'h53 : 8'h52;
		endcase
	endfunction
endpackage

// file: hw/lnkh_host.sv
`timescale 1ns/100ps
// Behaviour
// R01: ext word read takes 1..64 words, 1..32 bit units or 32 long counters.
// R02: head plus points minus one stays within highest device; bit unit spans 16.
// R03: ext word commands carry each long counter point as two data words.
// R04: station, controller number, count and checksum travel as hex characters.
// R05: bit block write takes 1..160 points, 46 on reduced families, within range.
// R06: bit block write sends one character per point in ascending order.
// R07: word block write takes 64 words or 10 units, 11 words on reduced.
// R08: word block write sends long counters as two words, 32 or 5 points.
// R09: a word-unit point on bit devices packs 16 bits into one word.
// R10: extended commands only go to targets marked as newer variants.
// R11: ext word write takes 1..64 words or 1..10 bit units.
// R12: bit test-write takes 1..20 addressed bits, 10 on reduced families.
// R13: word test-write takes 1..10 entries, 6 on reduced, words and units mixed.
// R14: word test-write refuses long counter devices.
// R15: ext word test-write takes 1..10 entries and refuses long counters.
// R16: remote run puts target into forced run via its two run flags.
// R17: remote run on a running target answers error 18H, state unchanged.
// R18: remote stop on a stopped target answers error 18H, state unchanged.
// R19: wait field is one hex digit in 10 ms steps, 0..150 ms.
// R20: after power cycle the target clears all forced-run flags and stops.
// R21: out-of-limit requests are refused and touch no device memory.
// R22: target applies writes only after frame and checksum are verified.
module lnkh_host import lnkh_pkg::*; #(
	parameter int BUF_WORDS = 64,
	parameter int RSP_TIMEOUT_CYC = RSP_TIMEOUT_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic [7:0] o_tx_data,
	output logic o_tx_valid,
	input wire logic i_tx_ready,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_valid,
	output logic o_busy
);
	localparam int BW = $clog2(BUF_WORDS);
	localparam int TW = $clog2(RSP_TIMEOUT_CYC + 1);

	typedef enum logic [3:0] {
		st_idle = 4'b0000, st_check = 4'b0001, st_enq = 4'b0011, st_stn = 4'b0010,
		st_cmd = 4'b0110, st_wait = 4'b0111, st_head = 4'b0101, st_cnt = 4'b0100,
		st_adr = 4'b1100, st_data = 4'b1101, st_sum = 4'b1111, st_rx = 4'b1110,
		st_done = 4'b1010
	} lnkh_state_t;
	typedef enum logic [1:0] {rx_first = 2'b00, rx_skip = 2'b01, rx_body = 2'b11, rx_csum = 2'b10} lnkh_rxph_t;

	lnkh_state_t state_r, state_nxt;
	lnkh_rxph_t rxph_r;
	lnkh_cfg_t cfg_r;
	lnkh_stat_t stat_r;
	logic [7:0] station_r, plc_r, count_r, idx_r, sum_r, rsum_r, err_code_r, tx_ch, chk_sum;
	logic [3:0] wait_r;
	logic [15:0] head_r, maxdev_r, acc_r;
	logic [1:0] nib_r, rnib_r;
	logic [BW-1:0] bidx_r, ridx_r, word_sel;
	logic [31:0] dbuf_r [BUF_WORDS];
	logic [31:0] cur_word;
	logic [TW-1:0] tmo_r;
	logic rx_is_nak_r, rx_word_wr;
	logic [7:0] lim;
	logic needs_ext, kind_ok, blk, unit16, remote, test, bitdata, wblk, last, tx_free, cmd_ok;
	logic [11:0] span;
	logic [17:0] last_dev;
	logic [8:0] nwords, items;
	logic start, sw_data_wr;

	assign start = i_wr && (i_addr == REG_CTRL) && i_wdata[CTRL_START_BIT] && (state_r == st_idle || state_r == st_done);
	assign sw_data_wr = i_wr && (i_addr == REG_DATA);
	assign tx_free = !o_tx_valid || i_tx_ready;

	// ************************************************************
	// request checking
	// ************************************************************
	always_comb begin
		lim = 8'h00;
		needs_ext = 1'b0;
		kind_ok = 1'b1;
		blk = 1'b0;
		case (cfg_r.cmd)
			ext_word_read_cmd: begin
				needs_ext = 1'b1; // see R10
				blk = 1'b1;
				lim = (cfg_r.kind == kind_word) ? LIM_WORD : (cfg_r.kind == kind_bit) ? LIM_BIT_RD : LIM_LONG; // see R01
			end
			word_block_write_cmd: begin
				blk = 1'b1;
				if (cfg_r.kind == kind_bit) begin
					lim = LIM_BIT_WR; // see R07
				end else if (cfg_r.kind == kind_long) begin
					lim = cfg_r.reduced ? LIM_LONG_RED : LIM_LONG; // see R08
				end else begin
					lim = cfg_r.reduced ? LIM_WORD_RED : LIM_WORD; // see R07
				end
			end
			ext_word_block_write_cmd: begin
				needs_ext = 1'b1; // see R10
				blk = 1'b1;
				lim = (cfg_r.kind == kind_word) ? LIM_WORD : (cfg_r.kind == kind_bit) ? LIM_BIT_WR : LIM_LONG; // see R11
			end
			bit_block_write_cmd: begin
				blk = 1'b1;
				kind_ok = (cfg_r.kind == kind_bit);
				lim = cfg_r.reduced ? LIM_BW_RED : LIM_BW; // see R05
			end
			bit_test_write_cmd: begin
				kind_ok = (cfg_r.kind == kind_bit);
				lim = cfg_r.reduced ? LIM_BT_RED : LIM_BT; // see R12
			end
			word_test_write_cmd: begin
				kind_ok = (cfg_r.kind != kind_long); // see R14
				lim = cfg_r.reduced ? LIM_WT_RED : LIM_WT; // see R13
			end
			ext_word_test_write_cmd: begin
				needs_ext = 1'b1; // see R10
				kind_ok = (cfg_r.kind != kind_long); // see R15
				lim = LIM_WT;
			end
			remote_run_cmd, remote_stop_cmd: lim = 8'h00;
			default: kind_ok = 1'b0;
		endcase
	end

	assign remote = (cfg_r.cmd == remote_run_cmd) || (cfg_r.cmd == remote_stop_cmd);
	assign test = (cfg_r.cmd == bit_test_write_cmd) || (cfg_r.cmd == word_test_write_cmd) ||
		(cfg_r.cmd == ext_word_test_write_cmd);
	assign bitdata = (cfg_r.cmd == bit_block_write_cmd) || (cfg_r.cmd == bit_test_write_cmd);
	assign wblk = blk && (cfg_r.cmd != ext_word_read_cmd);
	assign unit16 = blk && !bitdata && (cfg_r.kind == kind_bit);
	assign span = unit16 ? {count_r, 4'h0} : {4'h0, count_r}; // see R02 R09
	assign last_dev = {2'b00, head_r} + {6'h00, span} - 18'd1; // see R02
	assign nwords = (cfg_r.kind == kind_long && !bitdata) ? {count_r, 1'b0} : {1'b0, count_r}; // see R03 R08
	assign items = (bitdata || test) ? {1'b0, count_r} : nwords;
	assign cmd_ok = kind_ok && (!needs_ext || cfg_r.ext_ok) &&
		(remote || (count_r != 8'h00 && count_r <= lim)) && (!blk || last_dev <= {2'b00, maxdev_r}); // see R21

	// ************************************************************
	// frame character generator
	// ************************************************************
	assign word_sel = bitdata && !test ? BW'(idx_r[7:4]) : BW'(idx_r);
	assign cur_word = dbuf_r[word_sel];
	assign chk_sum = sum_r + tx_ch;

	always_comb begin
		tx_ch = CH_ENQ;
		last = 1'b1;
		case (state_r)
			st_stn: begin
				tx_ch = hex_ch(nib16({station_r, plc_r}, nib_r)); // see R04
				last = (nib_r == 2'd3);
			end
			st_cmd: begin
				tx_ch = cmd_ch(cfg_r.cmd, nib_r[0]);
				last = nib_r[0];
			end
			st_wait: tx_ch = hex_ch(wait_r); // see R19
			st_head: begin
				tx_ch = hex_ch(nib16(head_r, nib_r));
				last = (nib_r == 2'd3);
			end
			st_cnt: begin
				tx_ch = hex_ch(nib_r[0] ? count_r[3:0] : count_r[7:4]); // see R04
				last = nib_r[0];
			end
			st_adr: begin
				tx_ch = hex_ch(nib16(cur_word[31:16], nib_r));
				last = (nib_r == 2'd3);
			end
			st_data: begin
				if (bitdata) begin
					tx_ch = (test ? cur_word[0] : cur_word[idx_r[3:0]]) ? CH_ONE : CH_ZERO; // see R06
				end else begin
					tx_ch = hex_ch(nib16(cur_word[15:0], nib_r)); // see R09
					last = (nib_r == 2'd3);
				end
			end
			st_sum: begin
				tx_ch = hex_ch(nib_r[0] ? sum_r[3:0] : sum_r[7:4]); // see R04
				last = nib_r[0];
			end
			default: tx_ch = CH_ENQ;
		endcase
	end

	always_comb begin
		case (state_r)
			st_enq: state_nxt = st_stn;
			st_stn: state_nxt = st_cmd;
			st_cmd: state_nxt = st_wait;
			st_wait: state_nxt = remote ? st_sum : (test ? st_cnt : st_head);
			st_head: state_nxt = st_cnt;
			st_cnt: state_nxt = test ? st_adr : (wblk ? st_data : st_sum);
			st_adr: state_nxt = st_data;
			st_data: state_nxt = ({1'b0, idx_r} + 9'd1 == items) ? st_sum : (test ? st_adr : st_data);
			st_sum: state_nxt = st_rx;
			default: state_nxt = st_idle;
		endcase
	end

	// ************************************************************
	// sequencer: send frame, then take the answer
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_r <= st_idle;
			o_tx_valid <= 1'b0;
			o_tx_data <= 8'h00;
			nib_r <= 2'd0;
			idx_r <= 8'h00;
			sum_r <= 8'h00;
		end else begin
			if (i_tx_ready) begin
				o_tx_valid <= 1'b0;
			end
			case (state_r)
				st_idle, st_done: if (start) begin
					state_r <= st_check;
				end
				st_check: begin
					nib_r <= 2'd0;
					idx_r <= 8'h00;
					sum_r <= 8'h00;
					state_r <= cmd_ok ? st_enq : st_done; // see R21
				end
				st_rx: if (stat_r.done) begin
					state_r <= st_done;
				end
				default: if (tx_free) begin
					o_tx_data <= tx_ch;
					o_tx_valid <= 1'b1;
					if (state_r != st_enq && state_r != st_sum) begin
						sum_r <= chk_sum;
					end
					nib_r <= last ? 2'd0 : nib_r + 2'd1;
					if (state_r == st_data && last) begin
						idx_r <= idx_r + 8'd1;
					end
					if (last) begin
						state_r <= state_nxt;
					end
				end
			endcase
		end
	end

	// ************************************************************
	// answer parser and status
	// ************************************************************
	assign rx_word_wr = state_r == st_rx && i_rx_valid && rxph_r == rx_body && !rx_is_nak_r &&
		i_rx_data != CH_ETX && rnib_r == 2'd3;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			stat_r <= '0; // see R20
			rxph_r <= rx_first;
			rnib_r <= 2'd0;
			ridx_r <= '0;
			acc_r <= 16'h0000;
			rsum_r <= 8'h00;
			err_code_r <= 8'h00;
			rx_is_nak_r <= 1'b0;
			tmo_r <= '0;
		end else begin
			if (i_wr && i_addr == REG_CTRL && i_wdata[CTRL_CLEAR_BIT]) begin
				stat_r <= '{forced_run: stat_r.forced_run, busy: stat_r.busy, default: 1'b0};
			end
			if (state_r == st_check) begin
				stat_r <= '{forced_run: stat_r.forced_run, busy: cmd_ok, lim_err: !cmd_ok, done: !cmd_ok, default: 1'b0};
				rxph_r <= rx_first;
				rnib_r <= 2'd0;
				ridx_r <= '0;
				rsum_r <= 8'h00;
				err_code_r <= 8'h00;
				tmo_r <= '0;
			end
			if (state_r == st_rx && !stat_r.done) begin
				tmo_r <= tmo_r + TW'(1);
				if (tmo_r == TW'(RSP_TIMEOUT_CYC - 1)) begin
					stat_r.timeout <= 1'b1;
					stat_r.done <= 1'b1;
					stat_r.busy <= 1'b0;
				end else if (i_rx_valid) begin
					case (rxph_r)
						rx_first: begin
							rx_is_nak_r <= (i_rx_data == CH_NAK);
							rnib_r <= 2'd0;
							if (i_rx_data == CH_STX || i_rx_data == CH_NAK) begin
								rxph_r <= rx_skip;
							end else begin
								stat_r.done <= 1'b1;
								stat_r.busy <= 1'b0;
								stat_r.nak <= (i_rx_data != CH_ACK);
								if (i_rx_data == CH_ACK && cfg_r.cmd == remote_run_cmd) begin
									stat_r.forced_run <= 1'b1; // see R16
								end
								if (i_rx_data == CH_ACK && cfg_r.cmd == remote_stop_cmd) begin
									stat_r.forced_run <= 1'b0;
								end
							end
						end
						rx_skip: begin
							rsum_r <= rsum_r + i_rx_data;
							rnib_r <= rnib_r + 2'd1;
							if (rnib_r == 2'(RX_SKIP_CHARS - 1)) begin
								rxph_r <= rx_body;
							end
						end
						rx_body: begin
							rsum_r <= rsum_r + i_rx_data;
							rnib_r <= rnib_r + 2'd1;
							acc_r <= {acc_r[11:0], hex_val(i_rx_data)};
							if (rx_is_nak_r) begin
								err_code_r <= {err_code_r[3:0], hex_val(i_rx_data)};
								if (rnib_r[0]) begin
									stat_r.nak <= 1'b1;
									stat_r.done <= 1'b1;
									stat_r.busy <= 1'b0;
									stat_r.mode_same <= ({err_code_r[3:0], hex_val(i_rx_data)} == ERR_MODE_SAME); // see R17 R18
								end
							end else if (i_rx_data == CH_ETX) begin
								rxph_r <= rx_csum;
								rnib_r <= 2'd0;
							end else if (rnib_r == 2'd3) begin
								ridx_r <= ridx_r + BW'(1); // see R03
							end
						end
						default: begin
							rnib_r <= rnib_r + 2'd1;
							acc_r <= {acc_r[11:0], hex_val(i_rx_data)};
							if (rnib_r[0]) begin
								stat_r.sum_err <= ({acc_r[3:0], hex_val(i_rx_data)} != rsum_r);
								stat_r.done <= 1'b1;
								stat_r.busy <= 1'b0;
							end
						end
					endcase
				end
			end
		end
	end

	// ************************************************************
	// command port registers and data buffer
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cfg_r <= '{ext_ok: 1'b0, reduced: 1'b0, kind: kind_word, cmd: ext_word_read_cmd};
			station_r <= 8'h00;
			plc_r <= RST_PLC_NO;
			wait_r <= 4'h0;
			head_r <= 16'h0000;
			maxdev_r <= 16'h0000;
			count_r <= 8'h00;
			bidx_r <= '0;
		end else if (i_wr && (state_r == st_idle || state_r == st_done)) begin
			case (i_addr)
				REG_CMD: cfg_r <= lnkh_cfg_t'(i_wdata[7:0]);
				REG_STN: begin
					station_r <= i_wdata[7:0];
					plc_r <= i_wdata[15:8];
					wait_r <= i_wdata[19:16]; // see R19
				end
				REG_HEAD: begin
					head_r <= i_wdata[15:0];
					maxdev_r <= i_wdata[31:16];
				end
				REG_CNT: count_r <= i_wdata[7:0];
				REG_BIDX: bidx_r <= i_wdata[BW-1:0];
				REG_DATA: bidx_r <= bidx_r + BW'(1);
				default: bidx_r <= bidx_r;
			endcase
		end else if (i_rd && i_addr == REG_DATA) begin
			bidx_r <= bidx_r + BW'(1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (rx_word_wr) begin
			dbuf_r[ridx_r] <= {16'h0000, acc_r[11:0], hex_val(i_rx_data)};
		end else if (sw_data_wr && (state_r == st_idle || state_r == st_done)) begin
			dbuf_r[bidx_r] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata <= 32'h0000_0000;
			o_busy <= 1'b0;
		end else begin
			o_busy <= (state_r != st_idle) && (state_r != st_done);
			o_rdata <= 32'h0000_0000;
			if (i_rd) begin
				case (i_addr)
					REG_CMD: o_rdata <= {24'h000000, cfg_r};
					REG_STN: o_rdata <= {12'h000, wait_r, plc_r, station_r};
					REG_HEAD: o_rdata <= {maxdev_r, head_r};
					REG_CNT: o_rdata <= {24'h000000, count_r};
					REG_STAT: o_rdata <= {16'h0000, err_code_r, stat_r};
					REG_BIDX: o_rdata <= 32'(bidx_r);
					REG_DATA: o_rdata <= dbuf_r[bidx_r];
					REG_RXCNT: o_rdata <= 32'(ridx_r);
					default: o_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_qr_limit: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R01
		state_r == st_check && cfg_r.cmd == ext_word_read_cmd && cfg_r.kind == kind_bit && count_r > 8'd32
		|=> state_r == st_done && stat_r.lim_err) else $error("bit unit read over limit sent");
	a_bw_limit: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R05
		state_r == st_check && cfg_r.cmd == bit_block_write_cmd && cfg_r.reduced && count_r > 8'd46
		|=> ##1 !o_tx_valid && stat_r.lim_err) else $error("reduced bit block write over limit sent");
	a_ww_limit: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R07
		state_r == st_check && cfg_r.cmd == word_block_write_cmd && cfg_r.kind == kind_word &&
		cfg_r.reduced && count_r == 8'd12 |=> stat_r.lim_err) else $error("reduced word write of 12 accepted");
	a_qw_units: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R11
		state_r == st_check && cfg_r.cmd == ext_word_block_write_cmd && cfg_r.ext_ok && cfg_r.kind == kind_bit &&
		count_r == 8'd10 && last_dev <= {2'b00, maxdev_r} |=> state_r == st_enq) else $error("ten units refused");
	a_bt_limit: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R12
		state_r == st_check && cfg_r.cmd == bit_test_write_cmd && count_r == 8'd21
		|=> stat_r.lim_err) else $error("bit test-write of 21 accepted");
	a_wt_limit: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R13
		state_r == st_check && cfg_r.cmd == word_test_write_cmd && cfg_r.reduced && count_r == 8'd7
		|=> stat_r.lim_err) else $error("reduced word test-write of 7 accepted");
	a_ext_only: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R10
		state_r == st_check && needs_ext && !cfg_r.ext_ok |=> state_r == st_done ##1 !o_tx_valid)
		else $error("extended command sent to older target");
	a_long_refused: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R15
		state_r == st_check && test && cfg_r.kind == kind_long |=> stat_r.lim_err)
		else $error("test-write on long counters accepted");
	a_hex_field: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R04
		o_tx_valid && $past(state_r) == st_stn && $changed(o_tx_data)
		|-> (o_tx_data >= 8'h30 && o_tx_data <= 8'h39) || (o_tx_data >= 8'h41 && o_tx_data <= 8'h46))
		else $error("station field not hex");
endmodule

// file: verification/lnkh_dev_model.sv
`timescale 1ns/100ps
module lnkh_dev_model import lnkh_pkg::*; (
	input wire logic i_clk,
	input wire logic i_slow,
	input wire logic [7:0] i_data,
	input wire logic i_valid,
	output logic o_ready,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid
);
	// ************************************************************
	// target device: parses frames, answers ack or nak
	// ************************************************************
	logic [7:0] f[0:127];
	logic [15:0] mem[0:255];
	logic [7:0] q[$];
	logic run = 1'b0, flag_a = 1'b0, flag_b = 1'b0;
	int n = 0, len = 0, gap = 0, frames = 0;
	function automatic int hv(input logic [7:0] c);
		return (c >= 8'h41) ? int'(c) - 55 : int'(c) - 48;
	endfunction
	task automatic nak(input logic [7:0] a, input logic [7:0] b);
		q.push_back(CH_NAK);
		for (int i = 0; i < 4; i++) q.push_back(f[i]);
		q.push_back(a);
		q.push_back(b);
	endtask
	initial begin
		o_ready = 1'b0;
		o_rx_data = 8'h00;
		o_rx_valid = 1'b0;
	end
	always @(posedge i_clk) begin : link
		logic [7:0] s;
		int h;
		o_ready <= i_slow ? ~o_ready : 1'b1;
		// idle receive line toggles so a stale value is never mistaken for data
		if (gap > 0) begin
			gap--;
			o_rx_valid <= 1'b0;
			o_rx_data <= ~o_rx_data;
		end else if (q.size() > 0) begin
			o_rx_data <= q.pop_front();
			o_rx_valid <= 1'b1;
		end else begin
			o_rx_valid <= 1'b0;
			o_rx_data <= ~o_rx_data;
		end
		if (i_valid && o_ready) begin
			if (i_data == CH_ENQ) n = 0;
			else begin
				f[n] = i_data;
				n++;
				len = (n >= 7 && f[4] == 8'h52) ? 9 : (n >= 13 ? 15 + 4 * (hv(f[11]) * 16 + hv(f[12])) : 0);
				if (n == len) begin
					s = 8'h00;
					for (int i = 0; i < len - 2; i++) s += f[i];
					frames++;
					gap = 4;
					// memory is touched only once the sum matches
					if (s != 8'(hv(f[len - 2]) * 16 + hv(f[len - 1]))) nak(8'h30, 8'h32);
					else if (f[4] == 8'h52 && f[5] == 8'h52) begin
						if (run) nak(8'h31, 8'h38);
						else begin
							run = 1'b1;
							flag_a = 1'b1;
							flag_b = 1'b1;
							q.push_back(CH_ACK);
						end
					end else if (f[4] == 8'h52) begin
						if (!run) nak(8'h31, 8'h38);
						else begin
							run = 1'b0;
							q.push_back(CH_ACK);
						end
					end else begin
						h = hv(f[7]) * 4096 + hv(f[8]) * 256 + hv(f[9]) * 16 + hv(f[10]);
						for (int i = 0; i < (len - 15) / 4; i++) begin
							mem[8'(h + i)] = 16'(hv(f[13 + 4 * i]) * 4096 + hv(f[14 + 4 * i]) * 256
								+ hv(f[15 + 4 * i]) * 16 + hv(f[16 + 4 * i]));
						end
						q.push_back(CH_ACK);
					end
				end
			end
		end
	end
endmodule

// file: verification/lnkh_host_tb.sv
`timescale 1ns/100ps
module lnkh_host_tb import lnkh_pkg::*;;
	// ************************************************************
	// bench
	// ************************************************************
	logic i_clk, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, slow = 1'b0, i_tx_ready, i_rx_valid, o_tx_valid, o_busy;
	logic [7:0] i_addr = 8'h00, o_tx_data, i_rx_data;
	logic [31:0] i_wdata = 32'h0, o_rdata, st;
	int err_total = 0, total_checks = 0, n0;
	// refused requests: {cmd cfg, count, head}, highest device fixed at 0100
	logic [31:0] bad[22] = '{32'h92410000, 32'h92000000, 32'h820B0000, 32'hD20C0000, 32'hA2210000, 32'hA3210000,
		32'hE2060000, 32'h10010000, 32'h90410000, 32'h80210000, 32'h830B0000, 32'h81A10000,
		32'hC12F0000, 32'h84150000, 32'hC40B0000, 32'h950B0000, 32'hD5070000, 32'h960B0000,
		32'hA5010000, 32'hA6010000, 32'h92020100, 32'h820100F2};
	lnkh_host #(.RSP_TIMEOUT_CYC(200)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_tx_data(o_tx_data),
		.o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready), .i_rx_data(i_rx_data),
		.i_rx_valid(i_rx_valid), .o_busy(o_busy));
	lnkh_dev_model m (.i_clk(i_clk), .i_slow(slow), .i_data(o_tx_data), .i_valid(o_tx_valid),
		.o_ready(i_tx_ready), .o_rx_data(i_rx_data), .o_rx_valid(i_rx_valid));
	task automatic end_of_test();
		if (err_total == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	// clears old status first so a stale done bit cannot end the poll early
	task automatic go(input logic [7:0] c, input logic [7:0] n, input logic [15:0] hd);
		wr(REG_CTRL, 32'h2);
		wr(REG_CMD, {24'h0, c});
		wr(REG_STN, 32'h0000FF05);
		wr(REG_HEAD, {16'h0100, hd});
		wr(REG_CNT, {24'h0, n});
		wr(REG_CTRL, 32'h1);
		st = 32'h0;
		for (int k = 0; k < 300 && st[1] !== 1'b1; k++) rd(REG_STAT, st);
		chk(st[1], 1'b1);
		// busy is registered off the state, so it falls two edges after an answer sets done
		rd(REG_STAT, st);
		chk(o_busy, 1'b0);
	endtask
	task automatic t_regs();
		rd(REG_STAT, st);
		chk(st, 32'h0);
		rd(REG_CMD, st);
		chk(st, 32'h10);
		rd(REG_STN, st);
		chk(st, 32'h0000FF00);
		rd(8'h40, st);
		chk(st, 32'h0);
	endtask
	task automatic t_remote();
		go(8'h97, 8'h00, 16'h0);
		chk({st[7], st[6], st[3]}, 3'b100);
		chk({m.flag_a, m.flag_b, m.run}, 3'b111);
		chk({m.f[0], m.f[1], m.f[2], m.f[4], m.f[5], m.f[7], m.f[8]}, 56'h3035465252_4335);
		go(8'h97, 8'h00, 16'h0);
		chk({st[15:8], st[6], m.run}, 10'h063);
		go(8'h98, 8'h00, 16'h0);
		chk({st[6], m.run}, 2'b00);
		go(8'h98, 8'h00, 16'h0);
		chk({st[15:8], st[6], m.run}, 10'h062);
	endtask
	task automatic t_write();
		slow = 1'b1;
		wr(REG_BIDX, 32'h0);
		wr(REG_DATA, 32'h7BC9);
		go(8'h92, 8'h01, 16'h0010);
		chk(st[6:2], 5'h00);
		chk(m.mem[16], 16'h7BC9);
		chk({m.f[4], m.f[5], m.f[11], m.f[12]}, 32'h57573031);
		slow = 1'b0;
		wr(REG_BIDX, 32'h0);
		for (int i = 0; i < 10; i++) wr(REG_DATA, 32'h1000 + i);
		go(8'h83, 8'h0A, 16'h0020);
		chk({st[6:2], m.mem[32], m.mem[41]}, 37'h010001009);
	endtask
	task automatic t_limits();
		foreach (bad[i]) begin
			n0 = m.frames;
			go(bad[i][31:24], bad[i][23:16], bad[i][15:0]);
			chk({st[2], m.frames - n0}, 33'h100000000);
		end
	endtask
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		#500000;
		err_total++;
		end_of_test();
	end
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_regs();
		t_remote();
		t_write();
		t_limits();
		end_of_test();
	end
endmodule
